//--- verilog/alc_lamp_ctrl.v
// Purpose: automatic exterior lamp control with a network slave command port
// Assumes: all inputs synchronous to core_clk_in; frame layer delivers id and bytes
// Notes:   long tick counts are parameters so simulation can shorten them
//
// What this block does
// R1: automatic only with ignition, switch off, rheostat on
// R2: darkness energizes head, park, marker, tail lamps
// R3: dip lights low beams, main lights high
// R4: brightness switches all lamp outputs off
// R5: lamp change needs about thirty accumulated seconds
// R6: warning when switch park/on or automatic lamps on, not while flashing
// R7: after ignition off, lamps stay rheostat delay
// R8: rheostat off disables all automatic switching
// R9: light then dark waits filtering delay
// R10: answer only identifiers 0Ah and 0Bh
// R11: command frame has two bytes, first selects
// R12: 01h flashes park, 02h heads, others ignored
// R13: flash count 1 to 254, 255 forever
// R14: ignition on aborts any flash sequence
// R15: status response is 2, 4 or 8 bytes
// R16: checksum at 3, 5 or 9, kept separate
// R17: first two user status bytes are zero
// R18: integral at 4; flags, delay, sensor 6-8
// R19: stale checksum bytes left at 3 and 5
// R20: 128 ms samples drive saturating counter, dark flag
// R21: delay counter advances each second to duration
// R22: classic checksum sent, bad command frames rejected
// R23: flash has on and off phase, count per off
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`include "alc_lamp_regs.vh"
`default_nettype none

module alc_lamp_ctrl #(
   parameter integer TICK_CYC = `ALC_TICK_CYC,
   parameter integer SEC_CYC  = `ALC_SEC_CYC
) (
   input  wire       core_clk_in,
   input  wire       sys_rst_in,
   // vehicle inputs
   input  wire       ignition_in,
   input  wire       hl_switch_park_in,
   input  wire       hl_switch_on_in,
   input  wire       rheostat_on_in,
   input  wire       low_beam_select_in,
   input  wire [7:0] light_sensor_in,
   input  wire [7:0] delay_ctrl_in,
   // lamp outputs
   output reg        park_lamps_out,
   output reg        headlamp_low_out,
   output reg        headlamp_high_out,
   output reg        high_beam_ind_out,
   output reg        lights_on_warn_out,
   // frame layer
   input  wire       id_valid_in,
   input  wire [5:0] id_in,
   input  wire [1:0] resp_len_in,
   input  wire       rx_valid_in,
   input  wire [7:0] rx_data_in,
   output wire       tx_valid_out,
   output reg  [7:0] tx_data_out,
   input  wire       tx_ready_in,
   // register port
   input  wire [7:0] reg_addr_in,
   input  wire [31:0] reg_wdata_in,
   input  wire       reg_wr_in,
   input  wire       reg_rd_in,
   output reg  [31:0] reg_rdata_out
);

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_AUTO  = 2'h1;
   localparam [1:0] ST_DELAY = 2'h2;

   // classic checksum addition with end-around carry
   function [7:0] lin_add;
      input [7:0] acc;
      input [7:0] b;
      reg   [8:0] s;
      begin
         s = {1'b0, acc} + {1'b0, b};
         lin_add = s[7:0] + {7'h00, s[8]};
      end
   endfunction

   reg  [31:0] tick_cnt;
   reg  [31:0] sec_cnt;
   reg  [1:0]  lamp_st;
   reg         lamps_on;
   reg  [7:0]  integ;
   reg         dark_condition_flag;
   reg  [7:0]  delay_cnt;
   reg  [7:0]  thresh;
   reg  [7:0]  flash_phase;
   reg  [7:0]  phase_cnt;
   reg         flash_act;
   reg         flash_head;
   reg         flash_lit;
   reg         flash_forever;
   reg  [7:0]  flash_cnt;
   reg         cmd_act;
   reg  [1:0]  rx_phase;
   reg  [7:0]  rx_sum;
   reg  [7:0]  rx_sub;
   reg  [7:0]  rx_num;
   reg         cmd_ok;
   reg         tx_act;
   reg  [3:0]  tx_pos;
   reg  [3:0]  tx_last;
   reg  [7:0]  tx_sum;
   reg  [7:0]  scr_chk3;
   reg  [7:0]  scr_chk5;
   reg  [7:0]  next_sum;
   reg  [3:0]  next_pos;

   wire tick      = (tick_cnt == TICK_CYC - 1);
   wire sec_tick  = (sec_cnt == SEC_CYC - 1);
   wire manual_sw = hl_switch_park_in | hl_switch_on_in;
   wire auto_en   = ignition_in & ~manual_sw & rheostat_on_in;       // [R1]
   wire sens_dark = (light_sensor_in < thresh);
   wire [7:0] flags = {dark_condition_flag, lamps_on, (lamp_st == ST_DELAY),
                       flash_act, flash_head, ignition_in, rheostat_on_in, auto_en};

   assign tx_valid_out = tx_act;

   function [7:0] resp_byte;
      input [3:0] pos;
      begin
         case (pos)
            `ALC_CHK_POS_2:    resp_byte = scr_chk3;                  // [R19]
            `ALC_POS_INTEGRAL: resp_byte = integ;                     // [R18]
            `ALC_CHK_POS_4:    resp_byte = scr_chk5;                  // [R19]
            `ALC_POS_FLAGS:    resp_byte = flags;                     // [R18]
            `ALC_POS_DELAY:    resp_byte = delay_ctrl_in;             // [R18]
            `ALC_POS_SENSOR:   resp_byte = light_sensor_in;           // [R18]
            default:           resp_byte = 8'h00;                     // [R17]
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // time base
   always @(posedge core_clk_in) begin
      if (sys_rst_in || tick) begin
         tick_cnt <= 32'h0000_0000;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end

   always @(posedge core_clk_in) begin
      if (sys_rst_in || sec_tick || lamp_st != ST_DELAY) begin
         sec_cnt <= 32'h0000_0000;
      end else begin
         sec_cnt <= sec_cnt + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // light filter
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         integ               <= `ALC_INTEG_MIN;
         dark_condition_flag <= 1'b0;
      end else if (tick && ignition_in) begin                         // [R20]
         if (sens_dark && integ != `ALC_INTEG_MAX) begin
            integ <= integ + 8'h01;
         end else if (!sens_dark && integ != `ALC_INTEG_MIN) begin
            integ <= integ - 8'h01;
         end
         if (integ == `ALC_INTEG_MAX) begin                           // [R5] [R9]
            dark_condition_flag <= 1'b1;
         end else if (integ == `ALC_INTEG_MIN) begin
            dark_condition_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // lamp state machine
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         lamp_st   <= ST_IDLE;
         lamps_on  <= 1'b0;
         delay_cnt <= 8'h00;
      end else begin
         case (lamp_st)
            ST_IDLE: begin
               lamps_on <= 1'b0;
               if (ignition_in) begin
                  lamp_st <= ST_AUTO;
               end
            end
            ST_AUTO: begin
               if (!ignition_in) begin
                  delay_cnt <= 8'h00;
                  if (lamps_on && rheostat_on_in) begin               // [R7]
                     lamp_st <= ST_DELAY;
                  end else begin
                     lamps_on <= 1'b0;
                     lamp_st  <= ST_IDLE;
                  end
               end else if (auto_en) begin
                  lamps_on <= dark_condition_flag;                    // [R2] [R4]
               end else begin
                  lamps_on <= 1'b0;                                   // [R8]
               end
            end
            ST_DELAY: begin
               if (ignition_in) begin
                  lamp_st <= ST_AUTO;
               end else if (!rheostat_on_in || delay_cnt >= delay_ctrl_in) begin
                  lamps_on <= 1'b0;                                   // [R21] [R8]
                  lamp_st  <= ST_IDLE;
               end else if (sec_tick) begin
                  delay_cnt <= delay_cnt + 8'h01;                     // [R21]
               end
            end
            default: begin
               lamp_st  <= ST_IDLE;
               lamps_on <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // command frame receive
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         cmd_act  <= 1'b0;
         rx_phase <= 2'h0;
         rx_sum   <= 8'h00;
         rx_sub   <= 8'h00;
         rx_num   <= 8'h00;
         cmd_ok   <= 1'b0;
      end else begin
         cmd_ok <= 1'b0;
         if (id_valid_in) begin
            cmd_act  <= (id_in == `ALC_ID_CMD);                       // [R10]
            rx_phase <= 2'h0;
            rx_sum   <= 8'h00;
         end else if (rx_valid_in && cmd_act) begin
            case (rx_phase)
               2'h0: begin
                  rx_sub   <= rx_data_in;                             // [R11]
                  rx_sum   <= lin_add(rx_sum, rx_data_in);
                  rx_phase <= 2'h1;
               end
               2'h1: begin
                  rx_num   <= rx_data_in;
                  rx_sum   <= lin_add(rx_sum, rx_data_in);
                  rx_phase <= 2'h2;
               end
               default: begin
                  cmd_ok   <= (rx_data_in == ~rx_sum);                // [R22]
                  cmd_act  <= 1'b0;
                  rx_phase <= 2'h0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // flash sequencer
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         flash_act     <= 1'b0;
         flash_head    <= 1'b0;
         flash_lit     <= 1'b0;
         flash_forever <= 1'b0;
         flash_cnt     <= 8'h00;
         phase_cnt     <= 8'h00;
      end else if (ignition_in) begin
         flash_act <= 1'b0;                                           // [R14]
         flash_lit <= 1'b0;
      end else if (cmd_ok && (rx_sub == `ALC_SUB_PARK || rx_sub == `ALC_SUB_HEAD)
                   && rx_num != 8'h00) begin                          // [R12]
         flash_act     <= 1'b1;
         flash_head    <= (rx_sub == `ALC_SUB_HEAD);
         flash_lit     <= 1'b1;
         flash_forever <= (rx_num == `ALC_FLASH_FOREVER);             // [R13]
         flash_cnt     <= rx_num;
         phase_cnt     <= 8'h00;
      end else if (flash_act && tick) begin
         if (phase_cnt + 8'h01 >= flash_phase) begin                  // [R23]
            phase_cnt <= 8'h00;
            flash_lit <= ~flash_lit;
            if (!flash_lit) begin
               if (!flash_forever) begin
                  flash_cnt <= flash_cnt - 8'h01;                     // [R13]
                  if (flash_cnt == 8'h01) begin
                     flash_act <= 1'b0;
                     flash_lit <= 1'b0;
                  end
               end
            end
         end else begin
            phase_cnt <= phase_cnt + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // lamp drivers
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         park_lamps_out     <= 1'b0;
         headlamp_low_out   <= 1'b0;
         headlamp_high_out  <= 1'b0;
         high_beam_ind_out  <= 1'b0;
         lights_on_warn_out <= 1'b0;
      end else begin
         park_lamps_out     <= lamps_on | (flash_lit & ~flash_head);  // [R2]
         headlamp_low_out   <= (lamps_on | (flash_lit & flash_head)) & low_beam_select_in;
         headlamp_high_out  <= (lamps_on | (flash_lit & flash_head)) & ~low_beam_select_in;
         high_beam_ind_out  <= (lamps_on | (flash_lit & flash_head)) & ~low_beam_select_in; // [R3]
         lights_on_warn_out <= manual_sw | lamps_on;                  // [R6]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status response transmit
   always @* begin
      next_sum = lin_add(tx_sum, tx_data_out);
      next_pos = tx_pos + 4'h1;
   end

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         tx_act      <= 1'b0;
         tx_pos      <= 4'h1;
         tx_last     <= `ALC_CHK_POS_2;
         tx_sum      <= 8'h00;
         tx_data_out <= 8'h00;
         scr_chk3    <= 8'h00;
         scr_chk5    <= 8'h00;
      end else if (id_valid_in) begin
         tx_act      <= (id_in == `ALC_ID_STATUS);                    // [R10] [R15]
         tx_pos      <= 4'h1;
         tx_sum      <= 8'h00;
         tx_data_out <= 8'h00;                                        // [R17]
         case (resp_len_in)
            `ALC_LEN_2: tx_last <= `ALC_CHK_POS_2;                    // [R16]
            `ALC_LEN_4: tx_last <= `ALC_CHK_POS_4;
            default:    tx_last <= `ALC_CHK_POS_8;
         endcase
      end else if (tx_act && tx_ready_in) begin
         if (tx_pos == tx_last) begin
            tx_act <= 1'b0;
         end else begin
            tx_pos <= next_pos;
            tx_sum <= next_sum;
            if (next_pos == tx_last) begin
               tx_data_out <= ~next_sum;                              // [R22]
               if (next_pos == `ALC_CHK_POS_2) begin
                  scr_chk3 <= ~next_sum;                              // [R16]
               end
               if (next_pos == `ALC_CHK_POS_4) begin
                  scr_chk5 <= ~next_sum;
               end
            end else begin
               tx_data_out <= resp_byte(next_pos);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register port
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         thresh      <= `ALC_THRESH_RST;
         flash_phase <= `ALC_FLASH_PHASE_RST;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `ALC_REG_THRESH) begin
            thresh <= reg_wdata_in[7:0];
         end
         if (reg_addr_in == `ALC_REG_FLASH_PHASE) begin
            flash_phase <= reg_wdata_in[7:0];
         end
      end
   end

   always @(posedge core_clk_in) begin
      if (sys_rst_in || !reg_rd_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         case (reg_addr_in)
            `ALC_REG_THRESH:      reg_rdata_out <= {24'h00_0000, thresh};
            `ALC_REG_FLASH_PHASE: reg_rdata_out <= {24'h00_0000, flash_phase};
            `ALC_REG_STATUS:      reg_rdata_out <= {24'h00_0000, flags};
            `ALC_REG_INTEGRAL:    reg_rdata_out <= {24'h00_0000, integ};
            `ALC_REG_FLASH_CNT:   reg_rdata_out <= {24'h00_0000, flash_cnt};
            default:              reg_rdata_out <= 32'h0000_0000;
         endcase
      end
   end

endmodule

`default_nettype wire

//--- verilog/alc_lamp_regs.vh
// Purpose: constants for the automatic exterior lamp controller
// Assumes: 250 MHz core clock, word-aligned register port
// Notes:   register offsets are byte addresses
`ifndef ALC_LAMP_REGS_VH
`define ALC_LAMP_REGS_VH

// clock and timing
`define ALC_CLK_KHZ          250000
`define ALC_TICK_MS          128
`define ALC_SEC_MS           1000
`define ALC_TICK_CYC         (`ALC_TICK_MS * `ALC_CLK_KHZ)
`define ALC_SEC_CYC          (`ALC_SEC_MS * `ALC_CLK_KHZ)

// register offsets
`define ALC_REG_THRESH       8'h00
`define ALC_REG_FLASH_PHASE  8'h04
`define ALC_REG_STATUS       8'h08
`define ALC_REG_INTEGRAL     8'h0C
`define ALC_REG_FLASH_CNT    8'h10

// reset values
`define ALC_THRESH_RST       8'h80
`define ALC_FLASH_PHASE_RST  8'h04

// frame identifiers and subcommands
`define ALC_ID_STATUS        6'h0A
`define ALC_ID_CMD           6'h0B
`define ALC_SUB_PARK         8'h01
`define ALC_SUB_HEAD         8'h02
`define ALC_FLASH_FOREVER    8'hFF

// response sizes and checksum positions
`define ALC_LEN_2            2'h0
`define ALC_LEN_4            2'h1
`define ALC_CHK_POS_2        4'h3
`define ALC_CHK_POS_4        4'h5
`define ALC_CHK_POS_8        4'h9
`define ALC_POS_INTEGRAL     4'h4
`define ALC_POS_FLAGS        4'h6
`define ALC_POS_DELAY        4'h7
`define ALC_POS_SENSOR       4'h8

// integral counter limits
`define ALC_INTEG_MAX        8'hFF
`define ALC_INTEG_MIN        8'h00

`endif

//--- tb/alc_lamp_ctrl_sva.sv
// Purpose: port checker for the lamp controller
// Assumes: one clock domain, synchronous reset
// Notes:   bound into every alc_lamp_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module alc_lamp_ctrl_sva (
   input wire logic       core_clk_in,
   input wire logic       sys_rst_in,
   input wire logic       ignition_in,
   input wire logic       hl_switch_park_in,
   input wire logic       hl_switch_on_in,
   input wire logic       rheostat_on_in,
   input wire logic       low_beam_select_in,
   input wire logic       park_lamps_out,
   input wire logic       headlamp_low_out,
   input wire logic       headlamp_high_out,
   input wire logic       high_beam_ind_out,
   input wire logic       lights_on_warn_out,
   input wire logic       id_valid_in,
   input wire logic [5:0] id_in,
   input wire logic [1:0] resp_len_in,
   input wire logic       tx_valid_out,
   input wire logic [7:0] tx_data_out,
   input wire logic       tx_ready_in
);
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////////////////////////////////////////////
   chk_ind_follows: assert property (high_beam_ind_out == headlamp_high_out)
      else $error("indicator differs from high beam");
   chk_beams_excl: assert property (!(headlamp_low_out && headlamp_high_out))
      else $error("low and high beam together");
   chk_dip_no_high: assert property (low_beam_select_in [*2] |-> !headlamp_high_out)
      else $error("high beam while dip selected");
   chk_warn_manual: assert property ((hl_switch_park_in || hl_switch_on_in)
      |=> lights_on_warn_out)
      else $error("no warning with manual switch");
   chk_auto_forced: assert property ((ignition_in && (!rheostat_on_in ||
      hl_switch_park_in || hl_switch_on_in)) [*4]
      |-> !(park_lamps_out || headlamp_low_out || headlamp_high_out))
      else $error("lamps driven while automatic disabled");
   chk_other_id: assert property (id_valid_in && id_in != 6'h0A && !tx_valid_out
      |=> !tx_valid_out)
      else $error("answer to foreign identifier");
   chk_status_start: assert property (id_valid_in && id_in == 6'h0A
      |=> tx_valid_out && tx_data_out == 8'h00)
      else $error("status response start wrong");
   chk_tx_hold: assert property (tx_valid_out && !tx_ready_in && !id_valid_in
      |=> tx_valid_out && $stable(tx_data_out))
      else $error("response byte not held");
   chk_short_len: assert property (id_valid_in && id_in == 6'h0A && resp_len_in == 2'h0
      ##1 (tx_valid_out && tx_ready_in && !id_valid_in) [*3] |=> !tx_valid_out)
      else $error("short response length wrong");
   cov_long: cover property (id_valid_in && id_in == 6'h0A && resp_len_in == 2'h2);
   cov_auto_on: cover property ($rose(headlamp_low_out));
   cov_flash: cover property ($rose(park_lamps_out) && !ignition_in);
endmodule
bind alc_lamp_ctrl alc_lamp_ctrl_sva i_sva (.core_clk_in, .sys_rst_in, .ignition_in,
   .hl_switch_park_in, .hl_switch_on_in, .rheostat_on_in, .low_beam_select_in, .park_lamps_out,
   .headlamp_low_out, .headlamp_high_out, .high_beam_ind_out, .lights_on_warn_out, .id_valid_in,
   .id_in, .resp_len_in, .tx_valid_out, .tx_data_out, .tx_ready_in);
`default_nettype wire

//--- tb/alc_lin_master.sv
// Purpose: network master model for the lamp controller frame port
// Assumes: one clock, requests change just after a rising edge
// Notes:   random accept stalls while stall is set
`timescale 1ns/1ps
`default_nettype none
module alc_lin_master (
   input  wire logic       clk_in,
   output logic            id_valid_out,
   output logic [5:0]      id_out,
   output logic [1:0]      resp_len_out,
   output logic            rx_valid_out,
   output logic [7:0]      rx_data_out,
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_data_in,
   output logic            tx_ready_out
);
   logic [7:0] resp_q[$];
   logic       stall = 1'b0;
   integer     seed = 67797;
   initial begin
      id_valid_out = 1'b0;
      id_out = 6'h00;
      resp_len_out = 2'h0;
      rx_valid_out = 1'b0;
      rx_data_out = 8'h00;
      tx_ready_out = 1'b0;
   end
   function automatic logic [7:0] rnd();
      rnd = 8'($random(seed));
   endfunction
   function automatic logic [8:0] csum(input logic [8:0] s, input logic [7:0] b);
      csum = s + b;
      if (csum > 9'h0FF) csum = csum - 9'h0FF;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) begin
      if (tx_valid_in && tx_ready_out) resp_q.push_back(tx_data_in);
      tx_ready_out <= !stall || (($random(seed) & 3) != 0);
   end
   task send_id(input logic [5:0] id, input logic [1:0] len);
      @(posedge clk_in);
      id_valid_out <= 1'b1;
      id_out <= id;
      resp_len_out <= len;
      @(posedge clk_in);
      id_valid_out <= 1'b0;
      id_out <= ~id;
      resp_len_out <= ~len;
   endtask
   task send_byte(input logic [7:0] b);
      @(posedge clk_in);
      rx_valid_out <= 1'b1;
      rx_data_out <= b;
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_data_out <= ~b;
   endtask
   task send_cmd(input logic [7:0] sub, input logic [7:0] cnt, input logic bad);
      logic [8:0] s;
      s = ~csum(csum(9'h000, sub), cnt);
      send_id(6'h0B, 2'h0);
      send_byte(sub);
      send_byte(cnt);
      send_byte(s[7:0] ^ {7'h00, bad});
   endtask
   task get_status(input logic [1:0] len, input int n);
      resp_q.delete();
      send_id(6'h0A, len);
      repeat (200) if (resp_q.size() <= n) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

//--- tb/tb_alc_lamp_ctrl.sv
// Purpose: self-checking bench for the lamp controller
// Assumes: short tick and second counts
// Notes:   expected values come from the bench model
`timescale 1ns/1ps
`default_nettype none
module tb_alc_lamp_ctrl;
   localparam int TICK = 8;
   logic core_clk_in, sys_rst_in, ignition_in, hl_switch_park_in, hl_switch_on_in;
   logic rheostat_on_in, low_beam_select_in, park_lamps_out, headlamp_low_out;
   logic headlamp_high_out, high_beam_ind_out, lights_on_warn_out, id_valid_in;
   logic rx_valid_in, tx_valid_out, tx_ready_in, reg_wr_in, reg_rd_in, park_q, head_q;
   logic [7:0]  light_sensor_in, delay_ctrl_in, rx_data_in, tx_data_out, reg_addr_in;
   logic [5:0]  id_in;
   logic [1:0]  resp_len_in;
   logic [31:0] reg_wdata_in, reg_rdata_out;
   int          miscompares, compares, park_rises, head_rises, p0, k;
   alc_lamp_ctrl #(.TICK_CYC(TICK), .SEC_CYC(16)) i_dut (.core_clk_in, .sys_rst_in,
      .ignition_in, .hl_switch_park_in, .hl_switch_on_in, .rheostat_on_in, .low_beam_select_in,
      .light_sensor_in, .delay_ctrl_in, .park_lamps_out, .headlamp_low_out, .headlamp_high_out,
      .high_beam_ind_out, .lights_on_warn_out, .id_valid_in, .id_in, .resp_len_in, .rx_valid_in,
      .rx_data_in, .tx_valid_out, .tx_data_out, .tx_ready_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rd_in, .reg_rdata_out);
   alc_lin_master i_master (.clk_in(core_clk_in), .id_valid_out(id_valid_in), .id_out(id_in),
      .resp_len_out(resp_len_in), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
      .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in));
   initial begin
      core_clk_in = 1'b0;
      forever #2 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) begin
      park_q <= park_lamps_out;
      head_q <= headlamp_low_out | headlamp_high_out;
      if (park_lamps_out && !park_q) park_rises <= park_rises + 1;
      if ((headlamp_low_out | headlamp_high_out) && !head_q) head_rises <= head_rises + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task reg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1 cmp(reg_rdata_out, exp);
   endtask
   task status(input logic [1:0] len, input int n, input logic [7:0] integ);
      logic [8:0] s;
      s = 9'h000;
      i_master.get_status(len, n);
      for (int i = 0; i < n; i++) s = i_master.csum(s, i_master.resp_q[i]);
      cmp(i_master.resp_q.size(), n + 1);
      cmp(i_master.resp_q[0], 8'h00);
      cmp(i_master.resp_q[1], 8'h00);
      cmp(i_master.resp_q[n], {24'h00_0000, ~s[7:0]});
      if (n > 2) cmp(i_master.resp_q[3], integ);
      if (n > 4) cmp(i_master.resp_q[6], delay_ctrl_in);
      if (n > 4) cmp(i_master.resp_q[7], light_sensor_in);
   endtask
   task flash(input logic [7:0] sub, cnt, input logic bad, input int exp_p, exp_h);
      int h0;
      p0 = park_rises;
      h0 = head_rises;
      i_master.send_cmd(sub, cnt, bad);
      cyc(120);
      if (exp_p >= 0) cmp(park_rises - p0, exp_p);
      cmp(head_rises - h0, exp_h);
   endtask
   initial begin
      repeat (20000) @(posedge core_clk_in);
      miscompares++;
      tally_and_finish;
   end
   initial begin
      {sys_rst_in, ignition_in, rheostat_on_in, low_beam_select_in} = 4'hF;
      {hl_switch_park_in, hl_switch_on_in, reg_wr_in, reg_rd_in} = 4'h0;
      light_sensor_in = 8'hFF;
      delay_ctrl_in = 8'h03;
      reg_addr_in = 8'h00;
      reg_wdata_in = 32'h0000_0000;
      miscompares = 0;
      compares = 0;
      cyc(16);
      sys_rst_in <= 1'b0;
      reg_read(8'h00, 32'h0000_0080);
      reg_read(8'h04, 32'h0000_0004);
      reg_write(8'h04, 32'h0000_0002);
      reg_read(8'h04, 32'h0000_0002);
      reg_write(8'h0C, 32'h0000_0055);
      reg_read(8'h0C, 32'h0000_0000);
      reg_read(8'h14, 32'h0000_0000);
      status(2'h0, 2, 8'h00);
      status(2'h1, 4, 8'h00);
      status(2'h2, 8, 8'h00);
      i_master.send_id(6'h05, 2'h0);
      cyc(5);
      cmp(tx_valid_out, 1'b0);
      light_sensor_in <= i_master.rnd() & 8'h7F;
      cyc(200 * TICK);
      cmp(headlamp_low_out | park_lamps_out, 1'b0);
      repeat (100 * TICK) if (!headlamp_low_out) @(posedge core_clk_in);
      cyc(1);
      cmp({headlamp_low_out, park_lamps_out, lights_on_warn_out}, 3'h7);
      low_beam_select_in <= 1'b0;
      cyc(3);
      cmp({headlamp_low_out, headlamp_high_out, high_beam_ind_out}, 3'h3);
      i_master.stall <= 1'b1;
      status(2'h2, 8, 8'hFF);
      rheostat_on_in <= 1'b0;
      cyc(4);
      cmp(headlamp_high_out | park_lamps_out, 1'b0);
      rheostat_on_in <= 1'b1;
      hl_switch_park_in <= 1'b1;
      cyc(4);
      cmp({headlamp_high_out, lights_on_warn_out}, 2'h1);
      hl_switch_park_in <= 1'b0;
      cyc(4);
      ignition_in <= 1'b0;
      cyc(30);
      cmp(headlamp_high_out, 1'b1);
      cyc(50);
      cmp(headlamp_high_out | park_lamps_out, 1'b0);
      ignition_in <= 1'b1;
      light_sensor_in <= 8'h80 | i_master.rnd();
      cyc(200 * TICK);
      cmp(headlamp_high_out, 1'b1);
      repeat (100 * TICK) if (headlamp_high_out) @(posedge core_clk_in);
      cyc(1);
      cmp(headlamp_high_out | park_lamps_out, 1'b0);
      ignition_in <= 1'b0;
      flash(8'h01, 8'h02, 1'b0, 2, 0);
      flash(8'h01, 8'h01, 1'b0, 1, 0);
      flash(8'h02, 8'h01, 1'b0, -1, 1);
      flash(8'h01, 8'h02, 1'b1, 0, 0);
      flash(8'h00, 8'h02, 1'b0, 0, 0);
      for (k = 3; k < 16; k++) flash(k[7:0], 8'h02, 1'b0, 0, 0);
      p0 = park_rises;
      i_master.send_cmd(8'h01, 8'hFF, 1'b0);
      cyc(200);
      cmp(park_rises - p0 >= 5, 1'b1);
      rheostat_on_in <= 1'b0;
      ignition_in <= 1'b1;
      cyc(4);
      p0 = park_rises;
      cyc(100);
      cmp(park_rises - p0, 0);
      cmp(park_lamps_out, 1'b0);
      tally_and_finish;
   end
endmodule
`default_nettype wire
